// file: src/prs_pkg.sv
// Package with register map, field layout, reset values and timing for the reference path.
package prs_pkg;

  // Register word indices on the plain register port.
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_SMOOTH  = 4'h1;
  localparam logic [3:0] ADDR_MAVG    = 4'h2;
  localparam logic [3:0] ADDR_WIDTH   = 4'h3;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
  localparam logic [3:0] ADDR_IRQ_EN  = 4'h6;
  localparam logic [3:0] ADDR_DEV     = 4'h7;
  localparam logic [3:0] ADDR_EFF     = 4'h8;
  localparam logic [3:0] ADDR_CMD_POS = 4'h9;

  // Field widths and positions.
  localparam int SMOOTH_W   = 16;
  localparam int MAVG_W     = 14;
  localparam int WIDTH_W    = 31;
  localparam int GEAR_W     = 31;
  localparam int IRQ_W      = 3;
  localparam int IRQ_INPOS  = 0;
  localparam int IRQ_GEAR   = 1;
  localparam int IRQ_APPLY  = 2;
  localparam int EFF_MAVG_LSB = 16;

  // Reset values and the moving-average length limit.
  localparam logic [SMOOTH_W-1:0] SMOOTH_RST = 16'h0000;
  localparam logic [MAVG_W-1:0]   MAVG_RST   = 14'h0000;
  localparam logic [MAVG_W-1:0]   MAVG_MAX   = 14'h2710;
  localparam logic [WIDTH_W-1:0]  WIDTH_RST  = 31'h0000_0007;

  // Gear ratio limits: 0.001 <= num/den <= 4000.
  localparam logic [9:0]  GEAR_MIN_MUL = 10'h3e8;
  localparam logic [11:0] GEAR_MAX_MUL = 12'hfa0;

  // Control cycle of 0.1 ms at a 20 ns clock.
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS       = 100000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // In-position output condition selector.
  typedef enum logic [1:0] {
    PRS_COND_ALWAYS = 2'b00,
    PRS_COND_FILT   = 2'b01,
    PRS_COND_INPUT  = 2'b10
  } prs_cond_e;

  // Start-up sequence for the gear ratio settings.
  typedef enum logic [1:0] {
    PRS_ST_CAPTURE = 2'b00,
    PRS_ST_CHECK   = 2'b01,
    PRS_ST_RUN     = 2'b10
  } prs_state_e;

endpackage : prs_pkg

// file: src/prs_mavg_if.sv
// Interface between the reference path and its moving-average stage.
`timescale 1ns/1ps
`default_nettype none
interface prs_mavg_if;
  import prs_pkg::*;
  logic                     tick;
  logic                     clr;
  logic signed [31:0]       in_delta;
  logic        [MAVG_W-1:0] len;
  logic signed [31:0]       out_delta;
  logic                     out_valid;
  logic                     idle;
  logic                     ready;

  modport src (output tick, clr, in_delta, len, input out_delta, out_valid, idle, ready);
  modport filt (input tick, clr, in_delta, len, output out_delta, out_valid, idle, ready);
endinterface : prs_mavg_if
`default_nettype wire

// file: src/prs_mavg.sv
// Moving-average stage over a window of control cycles, keeping every count.
`timescale 1ns/1ps
`default_nettype none
module prs_mavg
  import prs_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  input  wire logic ce_in,
  prs_mavg_if.filt  mif
);

  typedef struct packed {
    logic [MAVG_W-1:0] idx;
    logic [MAVG_W-1:0] clr_idx;
    logic              clearing;
    logic signed [31:0] sum;
    logic signed [31:0] acc;
    logic signed [31:0] out_delta;
    logic              out_valid;
  } prs_mavg_s;

  prs_mavg_s          st_q;
  prs_mavg_s          st_d;
  logic signed [31:0] win_mem [0:10000-1];
  logic signed [31:0] old_v;
  logic signed [31:0] acc_n;
  logic signed [31:0] quo;
  logic               mem_we;
  logic [MAVG_W-1:0]  mem_addr;
  logic signed [31:0] mem_wd;

  assign mif.out_delta = st_q.out_delta;
  assign mif.out_valid = st_q.out_valid;
  assign mif.idle      = (st_q.sum == 32'sh0) && (st_q.acc == 32'sh0);
  assign mif.ready     = !st_q.clearing;

  // Window update: output is the window sum divided by its length, remainder carried on.
  always_comb
  begin
    st_d     = st_q;
    old_v    = win_mem[st_q.idx];
    acc_n    = 32'sh0;
    quo      = 32'sh0;
    mem_we   = 1'b0;
    mem_addr = st_q.idx;
    mem_wd   = 32'sh0;
    st_d.out_valid = 1'b0;
    if (mif.clr)
    begin
      st_d.clearing = 1'b1;
      st_d.clr_idx  = '0;
      st_d.idx      = '0;
      st_d.sum      = 32'sh0;
      st_d.acc      = 32'sh0;
    end
    else if (st_q.clearing)
    begin
      // Stale words would leak into a longer window, so the whole array is swept.
      mem_we   = 1'b1;
      mem_addr = st_q.clr_idx;
      st_d.clr_idx = st_q.clr_idx + 14'h0001;
      if (st_q.clr_idx == MAVG_MAX - 14'h0001)
        st_d.clearing = 1'b0;
    end
    else if (mif.tick)
    begin
      st_d.out_valid = 1'b1;
      if (mif.len == '0)
        st_d.out_delta = mif.in_delta;
      else
      begin
        mem_we   = 1'b1;
        mem_wd   = mif.in_delta;
        st_d.sum = st_q.sum + mif.in_delta - old_v;
        acc_n    = st_q.acc + st_d.sum;
        quo      = acc_n / $signed({18'h0, mif.len});
        st_d.acc = acc_n - 32'(quo * $signed({18'h0, mif.len}));
        st_d.out_delta = quo;
        st_d.idx = (st_q.idx == mif.len - 14'h0001) ? '0 : st_q.idx + 14'h0001;
      end
    end
  end

  // Window memory, written through one port.
  always_ff @(posedge ref_clk_in)
  begin
    if (ce_in && mem_we)
      win_mem[mem_addr] <= mem_wd;
  end

  // State register; a reset starts a sweep since the array has no reset.
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_q          <= '0;
      st_q.clearing <= 1'b1;
    end
    else if (ce_in)
      st_q <= st_d;
  end

endmodule : prs_mavg
`default_nettype wire

// file: src/prs_ref_path.sv
// Position reference path: pulse counting, smoothing, gear and in-position output.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module prs_ref_path
  import prs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  input  wire logic                ref_clk_in,
  input  wire logic                rstn_in,
  input  wire logic                ce_in,
  input  wire logic                ref_pulse_in,
  input  wire logic                ref_dir_in,
  input  wire logic signed [31:0]  fb_pos_in,
  input  wire logic [GEAR_W-1:0]   gear_numerator_in,
  input  wire logic [GEAR_W-1:0]   gear_denominator_in,
  input  wire logic [3:0]          addr_in,
  input  wire logic [31:0]         wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic [31:0]              rdata_out,
  output logic                     in_position_output_out,
  output logic                     irq_out,
  output logic                     gear_alarm_out,
  output logic signed [31:0]       motor_delta_out,
  output logic                     motor_valid_out
);

  typedef struct packed {
    prs_state_e          state;
    logic                p_s1;
    logic                p_s2;
    logic                p_prev;
    logic                d_s1;
    logic                d_s2;
    logic [15:0]         tick_cnt;
    logic signed [31:0]  in_cnt;
    logic signed [31:0]  in_delta;
    logic signed [31:0]  sm_res;
    logic                filt_zero;
    logic [SMOOTH_W-1:0] sm_time;
    logic [SMOOTH_W-1:0] sm_pend;
    logic [MAVG_W-1:0]   mavg_len;
    logic [MAVG_W-1:0]   mavg_pend;
    logic                mavg_tick;
    logic                mavg_clr;
    logic signed [31:0]  mavg_in;
    logic [WIDTH_W-1:0]  width;
    logic [1:0]          cond;
    logic [IRQ_W-1:0]    irq_st;
    logic [IRQ_W-1:0]    irq_en;
    logic signed [31:0]  cmd_pos;
    logic signed [32:0]  dev;
    logic [GEAR_W-1:0]   gear_num;
    logic [GEAR_W-1:0]   gear_den;
    logic signed [63:0]  gear_rem;
    logic                alarm;
    logic                inpos;
    logic                irq;
    logic [31:0]         rdata;
    logic signed [31:0]  motor_delta;
    logic                motor_valid;
  } prs_ref_s;

  prs_ref_s           st_q;
  prs_ref_s           st_d;
  prs_mavg_if         mif ();

  logic               edge_seen;
  logic signed [31:0] cnt_n;
  logic signed [31:0] res_n;
  logic signed [31:0] step;
  logic signed [63:0] gear_acc;
  logic signed [63:0] gear_q;
  logic [32:0]        dev_abs;
  logic               stopped;
  logic               below;
  logic               cond_ok;
  logic               tick_now;
  logic [IRQ_W-1:0]   irq_set;
  logic [IRQ_W-1:0]   irq_clr;

  // Smoothing step: a share of the residual, never zero while a count is pending.
  function automatic logic signed [31:0] smooth_step(input logic signed [31:0] res,
                                                     input logic [SMOOTH_W-1:0] tm);
    logic signed [31:0] q;
    q = 32'sh0;
    if (tm == '0)
      q = res;
    else
    begin
      q = res / $signed({16'h0, tm});
      if (q == 32'sh0 && res != 32'sh0)
        q = (res < 32'sh0) ? -32'sh1 : 32'sh1;
    end
    return q;
  endfunction : smooth_step

  // Magnitude of a signed deviation, one bit wider so the most negative value fits.
  function automatic logic [32:0] mag33(input logic signed [32:0] v);
    return v[32] ? 33'(-v) : 33'(v);
  endfunction : mag33

  assign mif.tick     = st_q.mavg_tick;
  assign mif.clr      = st_q.mavg_clr;
  assign mif.in_delta = st_q.mavg_in;
  assign mif.len      = st_q.mavg_len;

  prs_mavg u_mavg (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .ce_in      (ce_in),
    .mif        (mif)
  );

  // Outputs straight from the state register.
  assign rdata_out              = st_q.rdata;
  assign in_position_output_out = st_q.inpos;
  assign irq_out                = st_q.irq;
  assign gear_alarm_out         = st_q.alarm;
  assign motor_delta_out        = st_q.motor_delta;
  assign motor_valid_out        = st_q.motor_valid;

  // Next-state logic for the whole reference path.
  always_comb
  begin
    st_d      = st_q;
    edge_seen = 1'b0;
    cnt_n     = 32'sh0;
    res_n     = 32'sh0;
    step      = 32'sh0;
    gear_acc  = 64'sh0;
    gear_q    = 64'sh0;
    dev_abs   = 33'h0;
    stopped   = 1'b0;
    below     = 1'b0;
    cond_ok   = 1'b0;
    tick_now  = 1'b0;
    irq_set   = '0;
    irq_clr   = '0;
    st_d.mavg_tick   = 1'b0;
    st_d.mavg_clr    = 1'b0;
    st_d.motor_valid = 1'b0;
    st_d.rdata       = 32'h0;

    // Pin inputs pass two flip-flops before anything reads them.
    st_d.p_s1   = ref_pulse_in;
    st_d.p_s2   = st_q.p_s1;
    st_d.d_s1   = ref_dir_in;
    st_d.d_s2   = st_q.d_s1;
    st_d.p_prev = st_q.p_s2;
    edge_seen   = st_q.p_s2 && !st_q.p_prev;

    // Gear settings are caught once after reset release, then checked.
    case (st_q.state)
      PRS_ST_CAPTURE:
      begin
        st_d.gear_num = gear_numerator_in;
        st_d.gear_den = gear_denominator_in;
        st_d.state    = PRS_ST_CHECK;
      end
      PRS_ST_CHECK:
      begin
        if (st_q.gear_num == '0 || st_q.gear_den == '0
            || ({10'h0, st_q.gear_num} * {31'h0, GEAR_MIN_MUL}) < {10'h0, st_q.gear_den}
            || {12'h0, st_q.gear_num} > ({12'h0, st_q.gear_den} * {31'h0, GEAR_MAX_MUL}))
        begin
          st_d.alarm         = 1'b1;
          irq_set[IRQ_GEAR]  = 1'b1;
        end
        st_d.state = PRS_ST_RUN;
      end
      PRS_ST_RUN:
      begin
        st_d.state = PRS_ST_RUN;
      end
      default:
      begin
        st_d.state = PRS_ST_CAPTURE;
      end
    endcase

    // Count reference pulses within one control cycle.
    cnt_n = st_q.in_cnt;
    if (edge_seen)
      cnt_n = st_q.d_s2 ? st_q.in_cnt - 32'sh1 : st_q.in_cnt + 32'sh1;
    st_d.in_cnt = cnt_n;

    // Control-cycle tick: hand the count through smoothing to the moving average.
    tick_now = (st_q.tick_cnt == 16'(TICK_CYC - 1));
    if (tick_now)
    begin
      st_d.tick_cnt = 16'h0000;
      st_d.in_delta = cnt_n;
      st_d.in_cnt   = 32'sh0;
      res_n         = st_q.sm_res + cnt_n;
      // A restart requested last cycle has not reached the average yet, so a
      // step handed over now would be swept away with the memory.
      if (mif.ready && !st_q.mavg_clr)
      begin
        step           = smooth_step(res_n, st_q.sm_time);
        st_d.mavg_in   = step;
        st_d.mavg_tick = 1'b1;
      end
      // While the average sweeps its memory the counts wait in the residual.
      st_d.sm_res = res_n - step;
    end
    else
      st_d.tick_cnt = st_q.tick_cnt + 16'h0001;

    // Filtered reference goes to the commanded position and through the gear.
    if (mif.out_valid)
    begin
      st_d.cmd_pos   = st_q.cmd_pos + mif.out_delta;
      st_d.filt_zero = (mif.out_delta == 32'sh0);
      gear_acc = st_q.gear_rem + $signed(mif.out_delta) * $signed({33'h0, st_q.gear_num});
      gear_q   = gear_acc / $signed({33'h0, st_q.gear_den});
      if (st_q.state == PRS_ST_RUN && !st_q.alarm)
      begin
        st_d.gear_rem    = gear_acc - gear_q * $signed({33'h0, st_q.gear_den});
        st_d.motor_delta = 32'(gear_q);
        st_d.motor_valid = 1'b1;
      end
    end

    // New filter times wait until the motor is stopped, then the average restarts.
    // A restart never shares a cycle with a tick: the average drops a tick
    // that arrives beside its clear, and that tick may carry counts.
    stopped = (st_q.in_delta == 32'sh0) && (st_q.sm_res == 32'sh0) && mif.idle
              && st_q.filt_zero && mif.ready && !st_q.mavg_clr
              && !tick_now;
    if (stopped && (st_q.sm_pend != st_q.sm_time || st_q.mavg_pend != st_q.mavg_len))
    begin
      st_d.sm_time        = st_q.sm_pend;
      st_d.mavg_len       = st_q.mavg_pend;
      st_d.mavg_clr       = 1'b1;
      irq_set[IRQ_APPLY]  = 1'b1;
    end

    // Deviation and in-position status; nothing here feeds back into the path.
    st_d.dev = 33'(st_q.cmd_pos) - 33'(fb_pos_in);
    dev_abs  = mag33(st_q.dev);
    below    = dev_abs < {2'b00, st_q.width};
    case (st_q.cond)
      PRS_COND_ALWAYS: cond_ok = 1'b1;
      PRS_COND_FILT:   cond_ok = st_q.filt_zero && mif.idle;
      PRS_COND_INPUT:  cond_ok = (st_q.in_delta == 32'sh0);
      default:         cond_ok = 1'b1;
    endcase
    st_d.inpos = below && cond_ok && (st_q.state == PRS_ST_RUN);
    if (st_d.inpos && !st_q.inpos)
      irq_set[IRQ_INPOS] = 1'b1;

    // Register writes; address decode by an if/else-if chain.
    if (wr_in)
    begin
      if (addr_in == ADDR_CTRL)
        st_d.cond = wdata_in[1:0];
      else if (addr_in == ADDR_SMOOTH)
        st_d.sm_pend = wdata_in[SMOOTH_W-1:0];
      else if (addr_in == ADDR_MAVG)
      begin
        // The whole word is compared, so a large value cannot wrap into range.
        if (wdata_in > 32'(MAVG_MAX))
          st_d.mavg_pend = MAVG_MAX;
        else
          st_d.mavg_pend = wdata_in[MAVG_W-1:0];
      end
      else if (addr_in == ADDR_WIDTH)
        st_d.width = wdata_in[WIDTH_W-1:0];
      else if (addr_in == ADDR_IRQ_CLR)
        irq_clr = wdata_in[IRQ_W-1:0];
      else if (addr_in == ADDR_IRQ_EN)
        st_d.irq_en = wdata_in[IRQ_W-1:0];
    end

    // Sticky events: a set in the same cycle as its clear wins.
    st_d.irq_st = (st_q.irq_st & ~irq_clr) | irq_set;
    st_d.irq    = |(st_d.irq_st & st_d.irq_en);

    // Read data stand only in the cycle after the read strobe.
    if (rd_in)
    begin
      if (addr_in == ADDR_CTRL)
        st_d.rdata = {30'h0, st_q.cond};
      else if (addr_in == ADDR_SMOOTH)
        st_d.rdata = {16'h0, st_q.sm_pend};
      else if (addr_in == ADDR_MAVG)
        st_d.rdata = {18'h0, st_q.mavg_pend};
      else if (addr_in == ADDR_WIDTH)
        st_d.rdata = {1'b0, st_q.width};
      else if (addr_in == ADDR_STATUS)
        st_d.rdata = {29'h0, st_q.irq_st};
      else if (addr_in == ADDR_IRQ_EN)
        st_d.rdata = {29'h0, st_q.irq_en};
      else if (addr_in == ADDR_DEV)
        st_d.rdata = st_q.dev[31:0];
      else if (addr_in == ADDR_EFF)
        st_d.rdata = {2'b00, st_q.mavg_len, st_q.sm_time};
      else if (addr_in == ADDR_CMD_POS)
        st_d.rdata = st_q.cmd_pos;
      else
        st_d.rdata = 32'h0;
    end
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_q           <= '0;
      st_q.state     <= PRS_ST_CAPTURE;
      st_q.filt_zero <= 1'b1;
      st_q.sm_time   <= SMOOTH_RST;
      st_q.sm_pend   <= SMOOTH_RST;
      st_q.mavg_len  <= MAVG_RST;
      st_q.mavg_pend <= MAVG_RST;
      st_q.width     <= WIDTH_RST;
      st_q.gear_num  <= '0;
      st_q.gear_den  <= '0;
    end
    else if (ce_in)
      st_q <= st_d;
  end

endmodule : prs_ref_path
`default_nettype wire

// file: tb/prs_host_model.sv
// Host motion controller model that issues bursts of reference pulses.
`timescale 1ns/1ps
`default_nettype none
module prs_host_model (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       go_in,
  input  wire logic [7:0] n_in,
  input  wire logic       dir_in,
  output logic            pulse_out,
  output logic            dir_out,
  output var logic        busy_out
);
  logic [7:0] left_q;
  logic [1:0] ph_q;

  // Two cycles high and two low per pulse, so the input synchroniser never misses one.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      left_q <= 8'h00;
      ph_q <= 2'h0;
      busy_out <= 1'b0;
      dir_out <= 1'b0;
    end
    else if (!busy_out)
    begin
      if (go_in && n_in != 8'h00)
      begin
        left_q <= n_in;
        dir_out <= dir_in;
        busy_out <= 1'b1;
        ph_q <= 2'h0;
      end
    end
    else
    begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3)
      begin
        left_q <= left_q - 8'h01;
        busy_out <= (left_q != 8'h01);
      end
    end
  end

  // The pin rests low between bursts.
  assign pulse_out = busy_out && !ph_q[1];
endmodule : prs_host_model
`default_nettype wire

// file: tb/prs_ref_path_monitor.sv
// Concurrent checks on the reference path's top-level ports.
`timescale 1ns/1ps
`default_nettype none
module prs_ref_path_monitor
  import prs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  input wire logic               ref_clk_in,
  input wire logic               rstn_in,
  input wire logic               ce_in,
  input wire logic               rd_in,
  input wire logic [GEAR_W-1:0]  gear_numerator_in,
  input wire logic [GEAR_W-1:0]  gear_denominator_in,
  input wire logic [31:0]        rdata_out,
  input wire logic               in_position_output_out,
  input wire logic               irq_out,
  input wire logic               gear_alarm_out,
  input wire logic signed [31:0] motor_delta_out,
  input wire logic               motor_valid_out
);
  logic [2:0]  since_rst_q;
  int unsigned gap_q;
  logic        bad_ratio;

  // Wide products so a large setting cannot overflow the limit test.
  always_comb
  begin
    bad_ratio = gear_numerator_in == '0 || gear_denominator_in == '0 ||
                64'(gear_numerator_in) * 64'd1000 < 64'(gear_denominator_in) ||
                64'(gear_numerator_in) > 64'(gear_denominator_in) * 64'd4000;
  end

  // Cycles since reset release and since the last motor output.
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      since_rst_q <= 3'h0;
      gap_q <= TICK_CYC;
    end
    else
    begin
      if (since_rst_q != 3'h7)
        since_rst_q <= since_rst_q + 3'h1;
      gap_q <= motor_valid_out ? 0 : (gap_q < TICK_CYC ? gap_q + 1 : gap_q);
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  alarm_check_a: assert property (since_rst_q == 3'h4 |-> gear_alarm_out == bad_ratio)
    else $error("gear alarm disagrees with ratio limits");
  alarm_sticky_a: assert property (gear_alarm_out |=> gear_alarm_out)
    else $error("gear alarm dropped without reset");
  alarm_quiet_a: assert property (gear_alarm_out |-> !motor_valid_out)
    else $error("motor output during gear alarm");
  valid_gap_a: assert property (motor_valid_out |-> gap_q >= TICK_CYC - 1)
    else $error("motor outputs closer than one control cycle");
  delta_held_a: assert property (!motor_valid_out |-> $stable(motor_delta_out))
    else $error("motor delta changed without valid");
  read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read slot");
  inpos_start_a: assert property (since_rst_q < 3'h2 |-> !in_position_output_out)
    else $error("in-position before run state");
  freeze_a: assert property (!ce_in |=> $stable(in_position_output_out) && $stable(irq_out))
    else $error("outputs moved with clock enable low");
endmodule : prs_ref_path_monitor

bind prs_ref_path prs_ref_path_monitor #(.TICK_CYC(TICK_CYC)) i_prs_ref_path_monitor (
  .ref_clk_in, .rstn_in, .ce_in, .rd_in, .gear_numerator_in, .gear_denominator_in, .rdata_out,
  .in_position_output_out, .irq_out, .gear_alarm_out, .motor_delta_out, .motor_valid_out);
`default_nettype wire

// file: tb/test_prs_ref_path.sv
// Self-checking bench for the reference path driven by a host pulse model.
`timescale 1ns/1ps
`default_nettype none
module test_prs_ref_path;
  import prs_pkg::*;
  logic              clk, rstn, ce, pulse, dir, wr, rd, go, hdir, busy;
  logic              inpos, irq, alarm, mvalid;
  logic [3:0]        addr;
  logic [7:0]        hn;
  logic [31:0]       wdata, rdata, rv;
  logic signed [31:0] fb, mdelta;
  logic [GEAR_W-1:0] gnum, gden;
  int                n_mismatch, total_checks, motor_sum, cmd_model, seed, saw_low, mon_on, ex;
  int                pq[$];

  prs_ref_path #(.TICK_CYC(20)) i_prs_ref_path (
    .ref_clk_in(clk), .rstn_in(rstn), .ce_in(ce), .ref_pulse_in(pulse), .ref_dir_in(dir),
    .fb_pos_in(fb), .gear_numerator_in(gnum), .gear_denominator_in(gden), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .in_position_output_out(inpos), .irq_out(irq), .gear_alarm_out(alarm),
    .motor_delta_out(mdelta), .motor_valid_out(mvalid));

  prs_host_model i_prs_host_model (.clk_in(clk), .rstn_in(rstn), .go_in(go), .n_in(hn),
    .dir_in(hdir), .pulse_out(pulse), .dir_out(dir), .busy_out(busy));

  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Reference model side: sums motor output and watches the in-position level.
  always @(posedge clk)
  begin
    if (mvalid === 1'b1) motor_sum += mdelta;
    if (mon_on != 0 && inpos !== 1'b1) saw_low = 1;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // Bus cycles; an idle edge after each strobe keeps drives apart.
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg

  task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
    chk(what, rv, exp);
    @(posedge clk);
  endtask : rchk

  task automatic irqchk(input logic exp);
    repeat (2) @(posedge clk);
    #1 chk("irq", irq, exp);
  endtask : irqchk

  task automatic burst(input int n, input logic d);
    hn <= 8'(n);
    hdir <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    cmd_model += d ? -n : n;
    pq.push_back(d ? -n : n);
    for (int i = 0; i <= 4000; i++)
    begin
      @(posedge clk);
      #1 if (busy === 1'b0) break;
      if (i == 4000)
      begin
        n_mismatch++;
        stop_test();
      end
    end
  endtask : burst

  function automatic logic ratio_bad(input longint n, input longint d);
    return n == 0 || d == 0 || n * 1000 < d || n > d * 4000;
  endfunction : ratio_bad

  // Main sequence.
  initial
  begin
    {rstn, wr, rd, go, hdir, addr, wdata, hn, fb} = '0;
    ce = 1'b1;
    gnum = 31'h2;
    gden = 31'h1;
    {n_mismatch, total_checks, motor_sum, cmd_model, saw_low, mon_on} = '0;
    seed = 32'h29699567;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk("width", ADDR_WIDTH, 32'h7);
    rchk("smooth", ADDR_SMOOTH, 32'h0);
    rchk("mavg", ADDR_MAVG, 32'h0);
    rchk("ctrl", ADDR_CTRL, 32'h0);
    rchk("unmapped", 4'hf, 32'h0);
    chk("alarm", alarm, ratio_bad(gnum, gden));
    wreg(ADDR_MAVG, 32'd20000);
    rchk("mavg max", ADDR_MAVG, 32'd10000);
    wreg(ADDR_MAVG, 32'h0);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    repeat (10100) @(posedge clk);
    burst(1, 1'b0);
    repeat (60) @(posedge clk);
    chk("single", motor_sum, 32'd2);
    for (int i = 0; i < 4; i++) burst(($unsigned($random(seed)) % 20) + 1, i[0]);
    repeat (200) @(posedge clk);
    rchk("cmd", ADDR_CMD_POS, cmd_model);
    fb <= cmd_model - 7;
    repeat (4) @(posedge clk);
    #1 chk("at width", inpos, 1'b0);
    fb <= cmd_model + 6;
    repeat (4) @(posedge clk);
    #1 chk("below width", inpos, 1'b1);
    rchk("dev", ADDR_DEV, 32'hffff_fffa);
    fb <= cmd_model;
    wreg(ADDR_WIDTH, 32'h0);
    repeat (3) @(posedge clk);
    #1 chk("zero width", inpos, 1'b0);
    wreg(ADDR_WIDTH, 32'h4000_0000);
    // Each output condition against a stream of pulses.
    for (int c = 0; c < 3; c++)
    begin
      wreg(ADDR_CTRL, 32'(c));
      repeat (300) @(posedge clk);
      #1 saw_low = 0;
      mon_on = 1;
      burst(30, 1'b0);
      mon_on = 0;
      chk("cond", saw_low, c != 0);
    end
    wreg(ADDR_IRQ_EN, 32'h4);
    wreg(ADDR_SMOOTH, 32'h3);
    repeat (300) @(posedge clk);
    rchk("eff", ADDR_EFF, 32'h3);
    irqchk(1'b1);
    wreg(ADDR_IRQ_EN, 32'h0);
    irqchk(1'b0);
    wreg(ADDR_IRQ_EN, 32'h4);
    irqchk(1'b1);
    wreg(ADDR_IRQ_CLR, 32'h4);
    irqchk(1'b0);
    repeat (10100) @(posedge clk);
    // A time written while pulses flow must stay pending until the stop.
    fork
      burst(30, 1'b0);
      begin
        repeat (40) @(posedge clk);
        wreg(ADDR_MAVG, 32'h5);
        rchk("held", ADDR_EFF, 32'h3);
      end
    join
    repeat (3000) @(posedge clk);
    rchk("eff new", ADDR_EFF, 32'h0005_0003);
    repeat (10400) @(posedge clk);
    ex = 0;
    foreach (pq[i]) ex += 2 * pq[i];
    chk("total", motor_sum, ex);
    rstn <= 1'b0;
    gnum <= 31'h1;
    gden <= 31'd2000;
    // Feedback far from zero keeps in-position low, so only the alarm bit is set.
    fb <= 32'sh100;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("alarm", alarm, ratio_bad(gnum, gden));
    rchk("alarm bit", ADDR_STATUS, 32'h2);
    burst(5, 1'b0);
    // Wait out the memory sweep so the counts really reach the gear stage.
    repeat (10200) @(posedge clk);
    rchk("cmd after", ADDR_CMD_POS, 32'h5);
    chk("quiet", motor_sum, ex);
    stop_test();
  end
endmodule : test_prs_ref_path
`default_nettype wire
